// file: dtm_pkg.sv
// constants for the die thermal monitor control block
package dtm_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] FLAG_OFS = 8'h00;
   localparam logic [7:0] SENSE_OFS = 8'h01;
   localparam logic [7:0] MASK_OFS = 8'h02;
   localparam logic [7:0] CTRL_OFS = 8'h03;
   localparam logic [7:0] STAT_OFS = 8'h04;
   // ----------------------------------------
   // fields and reset values
   // ----------------------------------------
   localparam int NUM_WARN = 6;
   localparam int NUM_CHAN = 7;
   localparam int SD_CHAN = 6;
   localparam int MONITOR_ENABLE_BIT = 0;
   localparam int MONITOR_ALWAYS_ON_BIT = 1;
   localparam int STAT_TSD_BIT = 0;
   localparam int STAT_POWER_BIT = 1;
   localparam logic [5:0] FLAG_RST = 6'h00;
   localparam logic [5:0] MASK_RST = 6'h3f;
   localparam logic MON_EN_RST = 1'b1;
   localparam logic MON_AON_RST = 1'b0;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int DB_TIME_NS = 10000;
   localparam int SAMPLE_WINDOW_NS = 450000;
   localparam int SAMPLE_INTERVAL_NS = 3000000;
   localparam int DB_CYC = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] DB_LAST = 8'(DB_CYC - 1);
   localparam int WINDOW_CYC = SAMPLE_WINDOW_NS / CLK_PERIOD_NS;
   localparam int INTERVAL_CYC = SAMPLE_INTERVAL_NS / CLK_PERIOD_NS;
endpackage : dtm_pkg

// file: dtm_ctrl.sv
// die thermal monitor control: debounce, hysteresis, flags, sampling, shutdown
`timescale 1ns/10ps
module dtm_ctrl #(
   parameter int WINDOW_CYC = dtm_pkg::WINDOW_CYC,
   parameter int INTERVAL_CYC = dtm_pkg::INTERVAL_CYC
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sys_standby,
   input wire logic [6:0] ctr_above_lvl,
   input wire logic [6:0] ctr_above_hys,
   output logic mon_power,
   output logic tsd_req,
   output logic turn_on_inhibit,
   output logic host_irq_n
);
   // ctr_above_lvl: centre sensor above each level (bit 6 = shutdown level);
   // ctr_above_hys: centre sensor above level minus its hysteresis
   // the other die sensors have no port here: they only reach the analog mux

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   logic mon_en_reg;
   logic mon_aon_reg;
   logic [5:0] flag_reg;
   logic [5:0] mask_reg;
   logic [6:0] sense_reg;
   logic [7:0] db_cnt [7];
   logic [15:0] samp_cnt;
   logic mon_power_reg;
   logic irq_n_reg;
   logic [7:0] rdata_reg;
   logic continuous;
   logic sampling_on;
   logic [6:0] target;
   logic [6:0] db_done;
   logic [5:0] warn_rise;
   logic [5:0] flag_clr;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mon_en_reg <= dtm_pkg::MON_EN_RST;
         mon_aon_reg <= dtm_pkg::MON_AON_RST;
      end else if (reg_wr && hit(reg_addr, dtm_pkg::CTRL_OFS)) begin
         mon_en_reg <= reg_wdata[dtm_pkg::MONITOR_ENABLE_BIT];
         mon_aon_reg <= reg_wdata[dtm_pkg::MONITOR_ALWAYS_ON_BIT];
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mask_reg <= dtm_pkg::MASK_RST;
      end else if (reg_wr && hit(reg_addr, dtm_pkg::MASK_OFS)) begin
         mask_reg <= reg_wdata[5:0];
      end
   end

   // ----------------------------------------
   // sampling schedule
   // ----------------------------------------
   // standby never runs continuously whatever the always-on bit says
   assign continuous = mon_aon_reg && !sys_standby;
   assign sampling_on = mon_en_reg && (continuous || (samp_cnt < 16'(WINDOW_CYC)));

   always_ff @(posedge core_clk) begin
      if (srst || !mon_en_reg || continuous) begin
         samp_cnt <= 16'h0000;
      end else if (samp_cnt == 16'(INTERVAL_CYC - 1)) begin
         samp_cnt <= 16'h0000;
      end else begin
         samp_cnt <= samp_cnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mon_power_reg <= 1'b0;
      end else begin
         mon_power_reg <= sampling_on;
      end
   end

   // ----------------------------------------
   // debounce and hysteresis per channel
   // ----------------------------------------
   // a set sense compares against the lower threshold, so it only falls below it
   assign target = (sense_reg & ctr_above_hys) | (~sense_reg & ctr_above_lvl);

   always_comb begin
      for (int i = 0; i < dtm_pkg::NUM_CHAN; i++) begin
         db_done[i] = sampling_on && (target[i] != sense_reg[i]) && (db_cnt[i] == dtm_pkg::DB_LAST);
      end
   end

   // counters restart when the sensor powers down: a window never resumes a stale count
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < dtm_pkg::NUM_CHAN; i++) begin
         if (srst || !sampling_on || (target[i] == sense_reg[i]) || db_done[i]) begin
            db_cnt[i] <= 8'h00;
         end else begin
            db_cnt[i] <= db_cnt[i] + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || !mon_en_reg) begin
         sense_reg <= 7'h00;
      end else begin
         sense_reg <= sense_reg ^ db_done;
      end
   end

   // ----------------------------------------
   // interrupt flags
   // ----------------------------------------
   assign warn_rise = db_done[5:0] & ~sense_reg[5:0] & {6{mon_en_reg}};
   assign flag_clr = (reg_wr && hit(reg_addr, dtm_pkg::FLAG_OFS)) ? reg_wdata[5:0] : 6'h00;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         flag_reg <= dtm_pkg::FLAG_RST;
      end else begin
         // a crossing in the clearing cycle wins
         flag_reg <= (flag_reg & ~flag_clr) | warn_rise;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= !(|(flag_reg & ~mask_reg));
      end
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            dtm_pkg::FLAG_OFS: rdata_reg <= {2'b00, flag_reg};
            dtm_pkg::SENSE_OFS: rdata_reg <= {1'b0, sense_reg};
            dtm_pkg::MASK_OFS: rdata_reg <= {2'b00, mask_reg};
            dtm_pkg::CTRL_OFS: rdata_reg <= {6'h00, mon_aon_reg, mon_en_reg};
            dtm_pkg::STAT_OFS: rdata_reg <= {6'h00, mon_power_reg, sense_reg[dtm_pkg::SD_CHAN]};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign reg_rdata = rdata_reg;
   assign mon_power = mon_power_reg;
   // shutdown sense stays set until cooled past the shutdown hysteresis or the monitor is disabled
   assign tsd_req = sense_reg[dtm_pkg::SD_CHAN];
   assign turn_on_inhibit = sense_reg[dtm_pkg::SD_CHAN];
   assign host_irq_n = irq_n_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   irq_gate_a: assert property (@(posedge core_clk) disable iff (srst)
      (|(flag_reg & ~mask_reg)) |=> !host_irq_n)
      else $error("unmasked flag did not raise interrupt");

   irq_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
      ((flag_reg & ~mask_reg) == 6'h00) |=> host_irq_n)
      else $error("interrupt without unmasked flag");

   flag_set_a: assert property (@(posedge core_clk) disable iff (srst)
      $rose(sense_reg[0]) |-> flag_reg[0])
      else $error("level one crossing did not set flag");

   w1c_clear_a: assert property (@(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == dtm_pkg::FLAG_OFS && reg_wdata[0] && !warn_rise[0]) |=> !flag_reg[0])
      else $error("write one did not clear flag");

   w0_keep_a: assert property (@(posedge core_clk) disable iff (srst)
      (flag_reg[1] && !(reg_wr && reg_addr == dtm_pkg::FLAG_OFS && reg_wdata[1])) |=> flag_reg[1])
      else $error("flag lost without write one");

   off_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
      !mon_en_reg ##1 !mon_en_reg |-> (sense_reg == 7'h00) && !$rose(flag_reg[2]))
      else $error("disabled monitor shows sense or new flag");

   debounce_len_a: assert property (@(posedge core_clk) disable iff (srst)
      $changed(sense_reg[0]) && mon_en_reg |-> $past(db_cnt[0]) == dtm_pkg::DB_LAST)
      else $error("sense changed before debounce time");

   hyst_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (sense_reg[3] && ctr_above_hys[3] && mon_en_reg) |=> sense_reg[3])
      else $error("sense released above hysteresis point");

   aon_power_a: assert property (@(posedge core_clk) disable iff (srst)
      (mon_en_reg && mon_aon_reg && !sys_standby) |=> mon_power)
      else $error("always-on run did not keep monitor powered");

   sample_off_a: assert property (@(posedge core_clk) disable iff (srst)
      (!continuous && samp_cnt >= 16'(WINDOW_CYC)) |=> !mon_power)
      else $error("monitor powered outside sampling window");

   tsd_inhibit_a: assert property (@(posedge core_clk) disable iff (srst)
      (tsd_req && ctr_above_hys[6] && mon_en_reg) |=> tsd_req && turn_on_inhibit)
      else $error("shutdown released before cooling past hysteresis");

   lvl1_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[0] |=> flag_reg[0])
      else $error("level one rise did not set flag");

   lvl2_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[1] |=> flag_reg[1])
      else $error("level two rise did not set flag");

   lvl3_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[2] |=> flag_reg[2])
      else $error("level three rise did not set flag");

   lvl4_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[3] |=> flag_reg[3])
      else $error("level four rise did not set flag");

   lvl5_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[4] |=> flag_reg[4])
      else $error("level five rise did not set flag");

   lvl6_set_a: assert property (@(posedge core_clk) disable iff (srst)
      warn_rise[5] |=> flag_reg[5])
      else $error("level six rise did not set flag");

   flag_sense_a: assert property (@(posedge core_clk) disable iff (srst)
      $rose(flag_reg[5]) |-> $rose(sense_reg[5]))
      else $error("flag set without sense crossing");

   sense_off_a: assert property (@(posedge core_clk) disable iff (srst)
      !mon_en_reg |=> (sense_reg == 7'h00))
      else $error("sense kept while monitor disabled");

   off_noflag_a: assert property (@(posedge core_clk) disable iff (srst)
      !mon_en_reg |-> (warn_rise == 6'h00))
      else $error("flag raised while monitor disabled");

   power_off_a: assert property (@(posedge core_clk) disable iff (srst)
      !mon_en_reg |=> !mon_power)
      else $error("monitor powered while disabled");

   ctrl_write_a: assert property (@(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == dtm_pkg::CTRL_OFS && !reg_wdata[0]) |=> !mon_en_reg)
      else $error("enable bit write zero ignored");

   standby_samp_a: assert property (@(posedge core_clk) disable iff (srst)
      (sys_standby && samp_cnt >= 16'(WINDOW_CYC)) |=> !mon_power)
      else $error("standby powered outside sampling window");

   window_on_a: assert property (@(posedge core_clk) disable iff (srst)
      (mon_en_reg && !continuous && samp_cnt < 16'(WINDOW_CYC)) |=> mon_power)
      else $error("monitor not powered inside sampling window");

   samp_wrap_a: assert property (@(posedge core_clk) disable iff (srst)
      (mon_en_reg && !continuous && samp_cnt == 16'(INTERVAL_CYC - 1)) |=> (samp_cnt == 16'h0000))
      else $error("sampling interval did not wrap");

   samp_step_a: assert property (@(posedge core_clk) disable iff (srst)
      (mon_en_reg && !continuous && samp_cnt < 16'(INTERVAL_CYC - 1)) |=> (samp_cnt == $past(samp_cnt) + 16'h0001))
      else $error("sampling counter skipped");

   db_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      (sampling_on && target[6] != sense_reg[6] && db_cnt[6] < dtm_pkg::DB_LAST) |=> (sense_reg[6] == $past(sense_reg[6])))
      else $error("shutdown sense changed before debounce time");

   db_count_a: assert property (@(posedge core_clk) disable iff (srst)
      (sampling_on && target[0] != sense_reg[0] && !db_done[0]) |=> (db_cnt[0] == $past(db_cnt[0]) + 8'h01))
      else $error("debounce counter did not advance");

   db_restart_a: assert property (@(posedge core_clk) disable iff (srst)
      !sampling_on |=> (db_cnt[0] == 8'h00))
      else $error("debounce count kept across power down");

   sense_rise_a: assert property (@(posedge core_clk) disable iff (srst)
      (!sense_reg[1] && !ctr_above_lvl[1]) |=> !sense_reg[1])
      else $error("sense set below its level");

   hyst_lvl1_a: assert property (@(posedge core_clk) disable iff (srst)
      (sense_reg[0] && ctr_above_hys[0] && mon_en_reg) |=> sense_reg[0])
      else $error("level one sense released above hysteresis point");

   tsd_pair_a: assert property (@(posedge core_clk) disable iff (srst)
      (tsd_req == turn_on_inhibit))
      else $error("shutdown request and turn-on inhibit differ");

   tsd_set_a: assert property (@(posedge core_clk) disable iff (srst)
      (db_done[6] && !sense_reg[6]) |=> tsd_req)
      else $error("shutdown crossing did not request shutdown");

   masked_quiet_a: assert property (@(posedge core_clk) disable iff (srst)
      (mask_reg == 6'h3f) |=> host_irq_n)
      else $error("interrupt raised with all levels masked");

   w1c_lvl2_a: assert property (@(posedge core_clk) disable iff (srst)
      (reg_wr && reg_addr == dtm_pkg::FLAG_OFS && reg_wdata[1] && !warn_rise[1]) |=> !flag_reg[1])
      else $error("write one did not clear level two flag");
endmodule : dtm_ctrl

// file: dtm_sensor_model.sv
// die-centre sensor comparator model, driven by a temperature in degrees C
`timescale 1ns/10ps
module dtm_sensor_model #(
   parameter int SD_LVL = 165,
   parameter int SD_HYS = 15
) (
   input wire logic [7:0] temp_c,
   output logic [6:0] ctr_above_lvl,
   output logic [6:0] ctr_above_hys
);
   // only the centre sensor is modelled; no other sensor reaches the block
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         ctr_above_lvl[i] = temp_c >= 8'(80 + 15 * i);
         ctr_above_hys[i] = temp_c >= 8'(75 + 15 * i);
      end
      ctr_above_lvl[6] = temp_c >= 8'(SD_LVL);
      ctr_above_hys[6] = temp_c >= 8'(SD_LVL - SD_HYS);
   end
endmodule : dtm_sensor_model

// file: dtm_ctrl_bench.sv
// self-checking bench for the die thermal monitor control block
`timescale 1ns/10ps
module dtm_ctrl_bench;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sys_standby = 1'b0;
   logic [7:0] temp_c = 8'h19;
   logic [7:0] reg_rdata;
   logic [6:0] ctr_above_lvl;
   logic [6:0] ctr_above_hys;
   logic mon_power;
   logic tsd_req;
   logic turn_on_inhibit;
   logic host_irq_n;
   int n_fail = 0;
   int check_count = 0;
   int pw;
   dtm_sensor_model i_dtm_sensor_model (.temp_c(temp_c), .ctr_above_lvl(ctr_above_lvl),
      .ctr_above_hys(ctr_above_hys));
   // short sampling period keeps the run small; window still exceeds the debounce
   dtm_ctrl #(.WINDOW_CYC(300), .INTERVAL_CYC(1000)) i_dtm_ctrl (.core_clk(core_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sys_standby(sys_standby), .ctr_above_lvl(ctr_above_lvl), .ctr_above_hys(ctr_above_hys),
      .mon_power(mon_power), .tsd_req(tsd_req), .turn_on_inhibit(turn_on_inhibit), .host_irq_n(host_irq_n));
   initial forever #25 core_clk = ~core_clk;
   // ----------------------------------------
   // access and check tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask : rd
   // a full interval holds exactly one window whatever the phase
   task automatic pwr(input int exp);
      pw = 0;
      cyc(20);
      repeat (1000) begin
         @(posedge core_clk);
         #1 pw += int'(mon_power === 1'b1);
      end
      chk(16'(pw), 16'(exp));
   endtask : pwr
   task automatic wait_irq(input logic lvl);
      int k;
      // look just after the edge so the registered output has settled
      for (k = 0; k < 400 && host_irq_n !== lvl; k++) begin
         cyc(1);
         #1;
      end
      if (k == 400) begin
         n_fail++;
         finish_test();
      end
   endtask : wait_irq
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      cyc(8);
      srst <= 1'b0;
      rd(8'h00, 8'h00);
      rd(8'h02, 8'h3f);
      rd(8'h03, 8'h01);
      rd(8'h07, 8'h00);
      chk({15'h0000, host_irq_n}, 16'h0001);
      $display("test reset done");
      wr(8'h03, 8'h03);
      wr(8'h02, 8'h3e);
      @(posedge core_clk) temp_c <= 8'h64;
      cyc(150);
      rd(8'h01, 8'h00);
      wait_irq(1'b0);
      rd(8'h01, 8'h03);
      rd(8'h00, 8'h03);
      pwr(1000);
      $display("test continuous done");
      @(posedge core_clk) temp_c <= 8'h4e;
      cyc(210);
      rd(8'h01, 8'h01);
      @(posedge core_clk) temp_c <= 8'h46;
      cyc(210);
      rd(8'h01, 8'h00);
      wr(8'h00, 8'h00);
      rd(8'h00, 8'h03);
      wr(8'h00, 8'h01);
      rd(8'h00, 8'h02);
      wait_irq(1'b1);
      $display("test hysteresis done");
      @(posedge core_clk) temp_c <= 8'haa;
      cyc(210);
      #1 chk({14'h0000, tsd_req, turn_on_inhibit}, 16'h0003);
      rd(8'h04, 8'h03);
      rd(8'h00, 8'h3f);
      @(posedge core_clk) temp_c <= 8'ha0;
      cyc(210);
      rd(8'h01, 8'h7f);
      @(posedge core_clk) temp_c <= 8'h91;
      cyc(210);
      rd(8'h01, 8'h1f);
      #1 chk({14'h0000, tsd_req, turn_on_inhibit}, 16'h0000);
      $display("test shutdown done");
      wr(8'h00, 8'h3f);
      wr(8'h03, 8'h02);
      rd(8'h01, 8'h00);
      cyc(210);
      rd(8'h00, 8'h00);
      #1 chk({14'h0000, mon_power, host_irq_n}, 16'h0001);
      wr(8'h03, 8'h03);
      wait_irq(1'b0);
      rd(8'h00, 8'h1f);
      @(posedge core_clk) temp_c <= 8'h46;
      wr(8'h00, 8'h3f);
      $display("test disable done");
      wr(8'h03, 8'h01);
      pwr(300);
      @(posedge core_clk) sys_standby <= 1'b1;
      wr(8'h03, 8'h03);
      pwr(300);
      wr(8'h03, 8'h02);
      pwr(0);
      $display("test sampling done");
      finish_test();
   end
endmodule : dtm_ctrl_bench
